// ### rtl/turnoff_drive_map.svh
`ifndef TURNOFF_DRIVE_MAP_SVH
`define TURNOFF_DRIVE_MAP_SVH

// ---------------------------------------------------------------------------
// Register layout
// ---------------------------------------------------------------------------
`define CFG_RESET_VALUE        16'h0030
`define LEVEL_MSB              15
`define LEVEL_LSB              13
`define DURATION_MSB           12
`define DURATION_LSB           10
`define CURRENT_MSB            9
`define CURRENT_LSB            8
`define RESERVED_BIT           7
`define CHECK_DISABLE_BIT      6
`define SOFT_OFF_BIT           5
`define VREF_SELECT_BIT        4
`define PIN_FUNCTION_BIT       3
`define STRENGTH_MSB           2
`define STRENGTH_LSB           0

// ---------------------------------------------------------------------------
// Decode constants
// ---------------------------------------------------------------------------
`define LEVEL_BASE_VOLTS       4'h6
`define CURRENT_STEP_DECIAMPS  4'h3
`define CLOCK_PERIOD_NS        12'h032
`define PLATEAU_NS_0           12'h096
`define PLATEAU_NS_1           12'h12c
`define PLATEAU_NS_2           12'h1c2
`define PLATEAU_NS_3           12'h258
`define PLATEAU_NS_4           12'h3e8
`define PLATEAU_NS_5           12'h5dc
`define PLATEAU_NS_6           12'h7d0
`define PLATEAU_NS_7           12'h9c4
`define SEGMENTS_ALL           6'h3f
`define SEGMENTS_THIRD         6'h03
`define SEGMENTS_SIXTH         6'h01

`endif

// ### rtl/turnoff_drive_pkg.sv
package turnoff_drive_pkg;

    typedef struct packed {
        logic [15:0] cfg;
        logic        fault_flag;
        logic        alarm;
        logic [3:0]  level_volts;
        logic [11:0] duration_ns;
        logic [5:0]  duration_cycles;
        logic [3:0]  current_deciamps;
        logic [5:0]  segments;
    } state_t;

endpackage

// ### rtl/turnoff_drive_config_register.sv
`timescale 1ns/10ps
`include "turnoff_drive_map.svh"
// Overview of operation
// - Plateau level code in bits 15..13 maps to 6 V plus code volts; resets 0.
// - Plateau duration code in bits 12..10 maps 150 ns up to 2500 ns; resets 0.
// - Discharge current code in bits 9..8 maps to 0.3 A steps.
// - Writing the reserved bit 7 sets the check fault flag; bit resets zero.
// - Bit 6 zero keeps the configuration check running; one suppresses it.
// - Bit 5 one enables soft turn-off leaving the mid plateau; resets one.
// - Bit 4 selects reference: zero internal, one external; resets one.
// - Bit 3 zero: pins five and six are short-circuit inputs, pull-up off.
// - Bit 3 one: pins go to converter, short-circuit function disabled.
// - Strength code 0 all segments, 1 one third, others one sixth.
// - Check fault reaches primary alarm unless the fault_report_mask_in input masks it.
module turnoff_drive_config_register
    import turnoff_drive_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    input  wire logic        write_en_in,
    input  wire logic [15:0] write_data_in,
    input  wire logic        check_mismatch_in,
    input  wire logic        fault_clear_in,
    input  wire logic        fault_report_mask_in,
    output logic      [15:0] read_data_out,
    output logic      [2:0]  plateau_level_select_out,
    output logic      [3:0]  plateau_volts_out,
    output logic      [11:0] plateau_duration_ns_out,
    output logic      [5:0]  plateau_duration_cycles_out,
    output logic      [3:0]  plateau_current_deciamps_out,
    output logic             config_check_disable_out,
    output logic             soft_off_from_mid_enable_out,
    output logic             vref_external_out,
    output logic             short_circuit_pins_enable_out,
    output logic             pin_five_pullup_allowed_out,
    output logic             analog_pins_to_converter_out,
    output logic      [5:0]  drive_segments_out,
    output logic             config_check_fault_flag_out,
    output logic             primary_fault_alarm_out
);

    // -----------------------------------------------------------------------
    // Decode helpers
    // -----------------------------------------------------------------------
    function automatic logic [11:0] duration_of(input logic [2:0] code);
        logic [11:0] ns;
        ns = `PLATEAU_NS_0;
        unique case (code)
            3'h0: ns = `PLATEAU_NS_0;
            3'h1: ns = `PLATEAU_NS_1;
            3'h2: ns = `PLATEAU_NS_2;
            3'h3: ns = `PLATEAU_NS_3;
            3'h4: ns = `PLATEAU_NS_4;
            3'h5: ns = `PLATEAU_NS_5;
            3'h6: ns = `PLATEAU_NS_6;
            3'h7: ns = `PLATEAU_NS_7;
        endcase
        return ns;
    endfunction

    state_t state;
    state_t next_state;

    logic [2:0]  next_level_code;
    logic [2:0]  next_duration_code;
    logic [2:0]  next_strength;
    logic [11:0] next_cycles_wide;
    logic        reserved_write;
    logic        mismatch_counts;

    // -----------------------------------------------------------------------
    // Next-state logic
    // -----------------------------------------------------------------------
    always_comb begin
        next_state = state;
        if (write_en_in) begin
            next_state.cfg = write_data_in;
        end
        // A write that puts a one in the reserved position is taken as touching it.
        reserved_write  = write_en_in && write_data_in[`RESERVED_BIT];
        // The mismatch is ignored while the check is off, so live retuning is safe.
        mismatch_counts = check_mismatch_in && !state.cfg[`CHECK_DISABLE_BIT];
        // Set wins over clear so an event in the clearing cycle is not lost.
        if (fault_clear_in) begin
            next_state.fault_flag = 1'b0;
        end
        if (reserved_write || mismatch_counts) begin
            next_state.fault_flag = 1'b1;
        end
        next_state.alarm = next_state.fault_flag && !fault_report_mask_in;

        next_level_code    = next_state.cfg[`LEVEL_MSB:`LEVEL_LSB];
        next_duration_code = next_state.cfg[`DURATION_MSB:`DURATION_LSB];
        next_strength      = next_state.cfg[`STRENGTH_MSB:`STRENGTH_LSB];

        next_state.level_volts = `LEVEL_BASE_VOLTS + {1'b0, next_level_code};
        next_state.duration_ns = duration_of(next_duration_code);
        // Least time, so the cycle count rounds up.
        next_cycles_wide = (next_state.duration_ns + `CLOCK_PERIOD_NS - 12'h001)
                           / `CLOCK_PERIOD_NS;
        next_state.duration_cycles = next_cycles_wide[5:0];
        next_state.current_deciamps = `CURRENT_STEP_DECIAMPS
            * ({2'b00, next_state.cfg[`CURRENT_MSB:`CURRENT_LSB]} + 4'h1);

        if (next_strength == 3'h0) begin
            next_state.segments = `SEGMENTS_ALL;
        end else if (next_strength == 3'h1) begin
            next_state.segments = `SEGMENTS_THIRD;
        end else begin
            next_state.segments = `SEGMENTS_SIXTH;
        end
    end

    // -----------------------------------------------------------------------
    // State register
    // -----------------------------------------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            state.cfg              <= `CFG_RESET_VALUE;
            state.fault_flag       <= 1'b0;
            state.alarm            <= 1'b0;
            state.level_volts      <= `LEVEL_BASE_VOLTS;
            state.duration_ns      <= `PLATEAU_NS_0;
            state.duration_cycles  <= 6'h03;
            state.current_deciamps <= `CURRENT_STEP_DECIAMPS;
            state.segments         <= `SEGMENTS_ALL;
        end else begin
            state <= next_state;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    assign read_data_out                = state.cfg;
    assign plateau_level_select_out     = state.cfg[`LEVEL_MSB:`LEVEL_LSB];
    assign plateau_volts_out            = state.level_volts;
    assign plateau_duration_ns_out      = state.duration_ns;
    assign plateau_duration_cycles_out  = state.duration_cycles;
    assign plateau_current_deciamps_out = state.current_deciamps;
    assign config_check_disable_out     = state.cfg[`CHECK_DISABLE_BIT];
    assign soft_off_from_mid_enable_out = state.cfg[`SOFT_OFF_BIT];
    assign vref_external_out            = state.cfg[`VREF_SELECT_BIT];
    assign short_circuit_pins_enable_out = !state.cfg[`PIN_FUNCTION_BIT];
    assign pin_five_pullup_allowed_out  = state.cfg[`PIN_FUNCTION_BIT];
    assign analog_pins_to_converter_out = state.cfg[`PIN_FUNCTION_BIT];
    assign drive_segments_out           = state.segments;
    assign config_check_fault_flag_out  = state.fault_flag;
    assign primary_fault_alarm_out      = state.alarm;

endmodule

// ### sim/turnoff_drive_sva.sv
`timescale 1ns/10ps
module turnoff_drive_sva
    import turnoff_drive_pkg::*;
(
    input wire logic        clock_in, rst_in, write_en_in, check_mismatch_in,
    input wire logic        fault_report_mask_in, config_check_disable_out,
    input wire logic        short_circuit_pins_enable_out, analog_pins_to_converter_out,
    input wire logic        config_check_fault_flag_out, primary_fault_alarm_out,
    input wire logic [15:0] write_data_in, read_data_out,
    input wire logic [3:0]  plateau_volts_out, plateau_current_deciamps_out,
    input wire logic [5:0]  drive_segments_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (rst_in);
    AST_READBACK: assert property (write_en_in |=> read_data_out == $past(write_data_in))
        else $error("readback wrong");
    AST_VOLTS: assert property (write_en_in |=> plateau_volts_out ==
        4'h6 + $past(write_data_in[15:13])) else $error("plateau volts wrong");
    AST_AMPS: assert property (write_en_in |=> plateau_current_deciamps_out ==
        4'h3 * ({2'h0, $past(write_data_in[9:8])} + 4'h1)) else $error("current wrong");
    AST_SEGS: assert property (write_en_in |=> drive_segments_out ==
        ($past(write_data_in[2:0]) == 3'h0 ? 6'h3f :
        $past(write_data_in[2:0]) == 3'h1 ? 6'h03 : 6'h01)) else $error("segments");
    AST_RSV: assert property (write_en_in && write_data_in[7] |=> config_check_fault_flag_out)
        else $error("reserved write gave no fault");
    AST_CHK: assert property (check_mismatch_in && !config_check_disable_out |=>
        config_check_fault_flag_out) else $error("mismatch gave no fault");
    AST_QUIET: assert property (!config_check_fault_flag_out && config_check_disable_out &&
        !(write_en_in && write_data_in[7]) |=> !config_check_fault_flag_out) else $error("fault while off");
    AST_ALARM: assert property (1'b1 |=> primary_fault_alarm_out ==
        (config_check_fault_flag_out && !$past(fault_report_mask_in))) else $error("alarm wrong");
    AST_PINS: assert property (short_circuit_pins_enable_out == !analog_pins_to_converter_out
        && analog_pins_to_converter_out == read_data_out[3]) else $error("pin function wrong");
endmodule
bind turnoff_drive_config_register turnoff_drive_sva turnoff_drive_sva_inst (.*);

// ### sim/host_model.sv
`timescale 1ns/10ps
module host_model (
    input  wire logic        clock_in,
    output logic             write_en_out,
    output logic      [15:0] write_data_out
);
    logic [15:0] shadow = 16'h0030;
    initial begin
        write_en_out = 1'b0;
        write_data_out = 16'h0000;
    end
    // Released data is inverted so that a late sample of it cannot pass by luck.
    task wr(input logic [15:0] d);
        @(posedge clock_in) #1;
        write_en_out = 1'b1;
        write_data_out = d;
        shadow = d;
        @(posedge clock_in) #1;
        write_en_out = 1'b0;
        write_data_out = ~d;
    endtask
    task set_strength(input logic [2:0] s);
        if (!shadow[6]) wr(shadow | 16'h0040);
        wr({shadow[15:3], s});
    endtask
endmodule

// ### sim/turnoff_drive_config_register_tb.sv
`timescale 1ns/10ps
module turnoff_drive_config_register_tb import turnoff_drive_pkg::*; ;
    logic        clock_in, rst_in, write_en_in, check_mismatch_in, fault_clear_in;
    logic        fault_report_mask_in, config_check_disable_out, soft_off_from_mid_enable_out;
    logic        vref_external_out, short_circuit_pins_enable_out, pin_five_pullup_allowed_out;
    logic        analog_pins_to_converter_out, config_check_fault_flag_out, primary_fault_alarm_out;
    logic [15:0] write_data_in, read_data_out;
    logic [11:0] plateau_duration_ns_out;
    logic [5:0]  plateau_duration_cycles_out, drive_segments_out;
    logic [3:0]  plateau_volts_out, plateau_current_deciamps_out;
    logic [2:0]  plateau_level_select_out;
    logic [11:0] ns_tab [8] = '{12'h096, 12'h12c, 12'h1c2, 12'h258, 12'h3e8, 12'h5dc, 12'h7d0, 12'h9c4};
    logic [31:0] seed;
    int          n_mismatch, cmp_count;
    turnoff_drive_config_register turnoff_drive_config_register_inst (.*);
    host_model host_model_inst (.clock_in(clock_in), .write_en_out(write_en_in),
        .write_data_out(write_data_in));
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end
    function logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task chk_cfg(input logic [15:0] d);
        logic [11:0] c;
        c = (ns_tab[d[12:10]] + 12'h031) / 12'h032;
        chk(read_data_out, d);
        chk({12'h0, plateau_volts_out}, {12'h0, 4'h6 + {1'b0, d[15:13]}});
        chk({13'h0, plateau_level_select_out}, {13'h0, d[15:13]});
        chk({4'h0, plateau_duration_ns_out}, {4'h0, ns_tab[d[12:10]]});
        chk({10'h0, plateau_duration_cycles_out}, {4'h0, c});
        chk({12'h0, plateau_current_deciamps_out}, {12'h0, 4'h3 * ({2'h0, d[9:8]} + 4'h1)});
        chk({10'h0, drive_segments_out}, d[2:0] == 3'h0 ? 16'h3f : d[2:0] == 3'h1 ? 16'h3 : 16'h1);
        chk({12'h0, config_check_disable_out, soft_off_from_mid_enable_out, vref_external_out,
            short_circuit_pins_enable_out}, {12'h0, d[6], d[5], d[4], ~d[3]});
        chk({14'h0, pin_five_pullup_allowed_out, analog_pins_to_converter_out}, {14'h0, d[3], d[3]});
    endtask
    task chkf(input logic [1:0] e);
        chk({14'h0, config_check_fault_flag_out, primary_fault_alarm_out}, {14'h0, e});
    endtask
    task pulse(input logic m, input logic c);
        @(posedge clock_in) #1;
        check_mismatch_in = m;
        fault_clear_in = c;
        @(posedge clock_in) #1;
        check_mismatch_in = 1'b0;
        fault_clear_in = 1'b0;
    endtask
    task close_out;
        $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        logic [15:0] d;
        {rst_in, check_mismatch_in, fault_clear_in, fault_report_mask_in} = 4'h8;
        {seed, n_mismatch, cmp_count} = {32'he97b, 32'h0, 32'h0};
        repeat (2) @(posedge clock_in);
        #1 rst_in = 1'b0;
        chk_cfg(16'h0030);
        chkf(2'b00);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            d = {i[2:0], i[2:0], i[1:0], 1'b0, seed[6:3], i[2:0]};
            host_model_inst.wr(d);
            chk_cfg(d);
        end
        chkf(2'b00);
        host_model_inst.wr(16'h0080);
        chkf(2'b11);
        fault_report_mask_in = 1'b1;
        @(posedge clock_in) #1;
        chkf(2'b10);
        pulse(1'b0, 1'b1);
        fault_report_mask_in = 1'b0;
        host_model_inst.wr(16'h0000);
        pulse(1'b1, 1'b0);
        chkf(2'b11);
        pulse(1'b0, 1'b1);
        host_model_inst.set_strength(3'h5);
        chk_cfg(16'h0045);
        pulse(1'b1, 1'b0);
        chkf(2'b00);
        host_model_inst.wr(16'h00c5);
        chkf(2'b11);
        host_model_inst.wr(16'h0000);
        pulse(1'b0, 1'b1);
        chkf(2'b00);
        // A mismatch and a clear in one cycle must leave the flag set.
        pulse(1'b1, 1'b1);
        chkf(2'b11);
        close_out();
    end
endmodule
